// [hw/sysctl_pkg.sv]
// Constants and carrier types for the interrupt, reset and sleep control bank
package sysctl_pkg;

    // Register byte offsets, one aligned word each
    localparam int ADR_W = 4;
    localparam logic [3:0] OFS_APP_IRQ_RST = 4'h0;
    localparam logic [3:0] OFS_SLEEP_CTRL = 4'h4;

    // Key field of the interrupt/reset register
    localparam logic [15:0] WRITE_KEY = 16'h05fa;
    localparam logic [15:0] KEY_READBACK = 16'hfa05;
    localparam int KEY_LSB = 16;

    // Field positions
    localparam int ENDIAN_BIT = 15;
    localparam int SPLIT_LSB = 8;
    localparam int SPLIT_W = 3;
    localparam int RST_REQ_BIT = 2;
    localparam int WAKE_ANY_BIT = 4;
    localparam int DEEP_BIT = 2;
    localparam int AFTER_HANDLER_BIT = 1;

    // Values after reset
    localparam logic [2:0] SPLIT_RST = 3'h0;
    localparam logic WAKE_ANY_RST = 1'b0;
    localparam logic DEEP_RST = 1'b0;
    localparam logic AFTER_HANDLER_RST = 1'b0;

    // Fixed byte order of data accesses: 0 little, 1 big
    localparam logic ENDIAN_FIXED = 1'b0;

    // Priority width and the bits this build really holds
    localparam int PRIO_W = 8;
    localparam logic [7:0] PRIO_IMPL_MASK = 8'hff;

    // Classic Wishbone request and answer
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [ADR_W-1:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } wb_req_t;

    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } wb_rsp_t;

    // Priority comparison request and answer
    typedef struct packed {
        logic [PRIO_W-1:0] pend_prio;
        logic [PRIO_W-1:0] active_prio;
        logic active_valid;
    } prio_in_t;

    typedef struct packed {
        logic [PRIO_W-1:0] group;
        logic [PRIO_W-1:0] sub;
        logic preempt;
    } prio_out_t;

    // Core event strobes
    typedef struct packed {
        logic wfe_exec;
        logic sev_exec;
        logic irq_pend_new;
        logic irq_enabled;
        logic handler_to_thread;
    } core_ev_t;

    typedef enum logic [1:0] {MODE_RUN, MODE_WAIT_EVENT, MODE_SLEEP_EXIT} mode_t;

endpackage

// [hw/interrupt_reset_sleep_control.sv]
// Interrupt/reset control and sleep control register pair with wake logic
//----------------------------------------------------------------------
// Functional notes
//----------------------------------------------------------------------
`timescale 1ns/1ns
`default_nettype none

module interrupt_reset_sleep_control
    import sysctl_pkg::*;
(
    // Clock and reset
    input wire logic CLK,
    input wire logic RST_N,
    // Register bus
    input wire sysctl_pkg::wb_req_t WB_REQ,
    output sysctl_pkg::wb_rsp_t WB_RSP,
    // Priority split service
    input wire sysctl_pkg::prio_in_t PRIO_IN,
    output sysctl_pkg::prio_out_t PRIO_OUT,
    // Core events and external event pin
    input wire sysctl_pkg::core_ev_t CORE_EV,
    input wire logic EXT_EVENT,
    // Power and reset outputs
    output logic SLEEPING,
    output logic SLEEP_DEEP,
    output logic WAKE,
    output logic OUTER_RESET_REQUEST
);

    // All state of the block in one word
    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
        logic [2:0] split;
        logic wake_any;
        logic deep;
        logic after_handler;
        logic rst_req;
        logic ext_s1;
        logic ext_s2;
        logic ext_s3;
        logic ext_stable;
        logic ev_latch;
        mode_t mode;
        logic wake;
        logic [7:0] grp;
        logic [7:0] sub;
        logic preempt;
    } state_t;

    state_t st_r;
    state_t st_nxt;

    // Group mask for a split value: ones mark group bits
    function automatic logic [7:0] group_mask(input logic [2:0] n);
        logic [8:0] m;
        m = 9'h1fe << n;
        return m[7:0];
    endfunction

    //------------------------------------------------------------------
    // Next-state logic
    //------------------------------------------------------------------
    always_comb
    begin
        logic access;
        logic key_ok;
        logic ext_rise;
        logic pend_wake;
        logic any_event;
        logic [7:0] gmask;
        logic [7:0] pend_m;
        logic [7:0] act_grp;
        access = 1'b0;
        key_ok = 1'b0;
        ext_rise = 1'b0;
        pend_wake = 1'b0;
        any_event = 1'b0;
        gmask = 8'h00;
        pend_m = 8'h00;
        act_grp = 8'h00;

        st_nxt = st_r;
        st_nxt.ack = 1'b0;
        st_nxt.wake = 1'b0;

        // Bus access: one per request, no new access taken while ack stands
        access = WB_REQ.cyc && WB_REQ.stb && !st_r.ack;
        key_ok = WB_REQ.sel[3] && WB_REQ.sel[2]
            && (WB_REQ.dat[31:KEY_LSB] == WRITE_KEY);

        if (access)
        begin
            st_nxt.ack = 1'b1;
            case (WB_REQ.adr)
                OFS_APP_IRQ_RST:
                begin
                    st_nxt.rdata[31:KEY_LSB] = KEY_READBACK;
                    st_nxt.rdata[ENDIAN_BIT] = ENDIAN_FIXED;
                    st_nxt.rdata[14:11] = 4'h0;
                    st_nxt.rdata[SPLIT_LSB +: SPLIT_W] = st_r.split;
                    st_nxt.rdata[7:0] = 8'h00;
                    if (WB_REQ.we && key_ok)
                    begin
                        if (WB_REQ.sel[1])
                        begin
                            st_nxt.split = WB_REQ.dat[SPLIT_LSB +: SPLIT_W];
                        end
                        if (WB_REQ.sel[0] && WB_REQ.dat[RST_REQ_BIT])
                        begin
                            st_nxt.rst_req = 1'b1;
                        end
                    end
                end
                OFS_SLEEP_CTRL:
                begin
                    st_nxt.rdata = 32'h0000_0000;
                    st_nxt.rdata[WAKE_ANY_BIT] = st_r.wake_any;
                    st_nxt.rdata[DEEP_BIT] = st_r.deep;
                    st_nxt.rdata[AFTER_HANDLER_BIT] = st_r.after_handler;
                    if (WB_REQ.we && WB_REQ.sel[0])
                    begin
                        st_nxt.wake_any = WB_REQ.dat[WAKE_ANY_BIT];
                        st_nxt.deep = WB_REQ.dat[DEEP_BIT];
                        st_nxt.after_handler = WB_REQ.dat[AFTER_HANDLER_BIT];
                    end
                end
                default:
                begin
                    // Unmapped word: acked, reads zero, writes dropped
                    st_nxt.rdata = 32'h0000_0000;
                end
            endcase
        end

        // External pin: three stages, a change counts once s2 and s3 agree
        st_nxt.ext_s1 = EXT_EVENT;
        st_nxt.ext_s2 = st_r.ext_s1;
        st_nxt.ext_s3 = st_r.ext_s2;
        if ((st_r.ext_s2 == st_r.ext_s3) && (st_r.ext_s3 != st_r.ext_stable))
        begin
            st_nxt.ext_stable = st_r.ext_s3;
            ext_rise = st_r.ext_s3;
        end

        // disabled interrupts wake only when enabled by bit 4
        pend_wake = CORE_EV.irq_pend_new
            && (CORE_EV.irq_enabled || st_r.wake_any);
        any_event = pend_wake || CORE_EV.sev_exec || ext_rise;

        // Wait and sleep sequencing
        case (st_r.mode)
            MODE_RUN:
            begin
                if (CORE_EV.wfe_exec)
                begin
                    // latched or same-cycle event satisfies the wait
                    if (st_r.ev_latch || any_event)
                    begin
                        st_nxt.ev_latch = 1'b0;
                    end
                    else
                    begin
                        st_nxt.mode = MODE_WAIT_EVENT;
                    end
                end
                else
                begin
                    // event held for the next wait
                    st_nxt.ev_latch = st_r.ev_latch || any_event;
                    if (CORE_EV.handler_to_thread && st_r.after_handler)
                    begin
                        st_nxt.mode = MODE_SLEEP_EXIT;
                    end
                end
            end
            MODE_WAIT_EVENT:
            begin
                if (any_event)
                begin
                    st_nxt.mode = MODE_RUN;
                    st_nxt.wake = 1'b1;
                end
            end
            MODE_SLEEP_EXIT:
            begin
                // Events still latch while asleep after a handler
                st_nxt.ev_latch = st_r.ev_latch || any_event;
                // Only an enabled interrupt brings the core back
                if (CORE_EV.irq_pend_new && CORE_EV.irq_enabled)
                begin
                    st_nxt.mode = MODE_RUN;
                    st_nxt.wake = 1'b1;
                end
            end
            default:
            begin
                st_nxt.mode = MODE_RUN;
            end
        endcase

        // missing low bits forced to zero
        pend_m = PRIO_IN.pend_prio & PRIO_IMPL_MASK;
        gmask = group_mask(st_r.split);
        st_nxt.grp = pend_m & gmask;
        st_nxt.sub = pend_m & ~gmask;
        act_grp = PRIO_IN.active_prio & PRIO_IMPL_MASK & gmask;
        st_nxt.preempt = !PRIO_IN.active_valid || (st_nxt.grp < act_grp);
    end

    //------------------------------------------------------------------
    // State register
    //------------------------------------------------------------------
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            st_r <= '0;
            st_r.split <= SPLIT_RST;
            st_r.wake_any <= WAKE_ANY_RST;
            st_r.deep <= DEEP_RST;
            st_r.after_handler <= AFTER_HANDLER_RST;
            st_r.mode <= MODE_RUN;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // Outputs straight from the state word
    assign WB_RSP.ack = st_r.ack;
    assign WB_RSP.dat = st_r.rdata;
    assign PRIO_OUT.group = st_r.grp;
    assign PRIO_OUT.sub = st_r.sub;
    assign PRIO_OUT.preempt = st_r.preempt;
    assign SLEEPING = (st_r.mode != MODE_RUN);
    assign SLEEP_DEEP = (st_r.mode != MODE_RUN) && st_r.deep;
    assign WAKE = st_r.wake;
    // level held until the outer system resets us
    assign OUTER_RESET_REQUEST = st_r.rst_req;

endmodule

`default_nettype wire

// [verification/sysctl_chk.sv]
// Checker for the system control register pair
`timescale 1ns/1ns
`default_nettype none
module sysctl_chk
    import sysctl_pkg::*;
(
    // Clock and reset
    input wire logic CLK,
    input wire logic RST_N,
    // Observed ports
    input wire sysctl_pkg::wb_req_t WB_REQ,
    input wire sysctl_pkg::wb_rsp_t WB_RSP,
    input wire sysctl_pkg::prio_in_t PRIO_IN,
    input wire sysctl_pkg::prio_out_t PRIO_OUT,
    input wire logic SLEEPING,
    input wire logic SLEEP_DEEP,
    input wire logic WAKE,
    input wire logic OUTER_RESET_REQUEST
);
    //----
    // Properties
    //----
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_N);
    logic req, rd0, rd4, wr0;
    // Taken bus requests by kind
    assign req = WB_REQ.cyc && WB_REQ.stb && !WB_RSP.ack;
    assign rd0 = req && !WB_REQ.we && WB_REQ.adr == OFS_APP_IRQ_RST;
    assign rd4 = req && !WB_REQ.we && WB_REQ.adr == OFS_SLEEP_CTRL;
    assign wr0 = req && WB_REQ.we && WB_REQ.adr == OFS_APP_IRQ_RST && WB_REQ.sel == 4'hf;
    ack_once_a: assert property (req |=> WB_RSP.ack ##1 !WB_RSP.ack)
        else $error("ack not a single pulse");
    key_read_a: assert property (rd0 |=> WB_RSP.dat[31:15] == {KEY_READBACK, ENDIAN_FIXED}
        && WB_RSP.dat[7:0] == 8'h00) else $error("bad key or low bits");
    rsvd_zero_a: assert property (rd0 |=> WB_RSP.dat[14:11] == 4'h0)
        else $error("reserved bits not zero");
    sleep_rsvd_a: assert property (rd4 |=> WB_RSP.dat[31:5] == 27'h0 && !WB_RSP.dat[3]
        && !WB_RSP.dat[0]) else $error("sleep reserved bits set");
    reset_req_a: assert property (wr0 && WB_REQ.dat[31:16] == WRITE_KEY && WB_REQ.dat[2]
        |=> OUTER_RESET_REQUEST) else $error("reset request missing");
    no_key_a: assert property (wr0 && WB_REQ.dat[31:16] != WRITE_KEY && !OUTER_RESET_REQUEST
        |=> !OUTER_RESET_REQUEST) else $error("unkeyed write acted");
    split_a: assert property ($past(RST_N) |-> (PRIO_OUT.group | PRIO_OUT.sub) ==
        $past(PRIO_IN.pend_prio) && (PRIO_OUT.group & PRIO_OUT.sub) == 8'h00)
        else $error("split does not partition");
    preempt_a: assert property ($past(RST_N) && !$past(PRIO_IN.active_valid)
        |-> PRIO_OUT.preempt) else $error("no preempt when idle");
    deep_a: assert property (SLEEP_DEEP |-> SLEEPING)
        else $error("deep without sleep");
    wake_pulse_a: assert property (WAKE |-> $past(SLEEPING) ##1 !WAKE)
        else $error("bad wake pulse");
endmodule
`default_nettype wire

// [verification/tb_top.sv]
// Self-checking bench for the system control register pair
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import sysctl_pkg::*;
    logic clk, rst_n, ext_ev, sleeping, deep, wake, rst_req;
    wb_req_t req;
    wb_rsp_t rsp;
    prio_in_t pin;
    prio_out_t pout;
    core_ev_t ev;
    logic [31:0] rd;
    logic [7:0] msk;
    int errors, check_count, wake_count, wake_base;
    interrupt_reset_sleep_control interrupt_reset_sleep_control_i (.CLK(clk), .RST_N(rst_n),
        .WB_REQ(req), .WB_RSP(rsp), .PRIO_IN(pin), .PRIO_OUT(pout), .CORE_EV(ev),
        .EXT_EVENT(ext_ev), .SLEEPING(sleeping), .SLEEP_DEEP(deep), .WAKE(wake),
        .OUTER_RESET_REQUEST(rst_req));
    //----
    // Clock, monitors and tasks
    //----
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Wake is a one-cycle pulse, so count the pulses
    always @(posedge clk)
        if (wake === 1'b1) wake_count <= wake_count + 1;
    task automatic test_done();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            errors++;
            $display("[ERR] %s exp %h seen %h", name, exp, seen);
        end
    endtask
    // Classic cycle; ack and read data taken at the same rising edge
    task automatic wb(logic we, logic [3:0] adr, logic [31:0] dat);
        int n;
        n = 0;
        @(posedge clk);
        req <= '{1'b1, 1'b1, we, adr, 4'hf, dat};
        do
        begin
            @(posedge clk);
            n++;
            if (n > 20)
            begin
                errors++;
                test_done();
            end
        end
        while (rsp.ack !== 1'b1);
        rd = rsp.dat;
        req.cyc <= 1'b0;
        req.stb <= 1'b0;
    endtask
    task automatic wt(int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask
    task automatic pulse(logic [4:0] e);
        @(posedge clk);
        ev <= e;
        @(posedge clk);
        ev <= '0;
        wt(3);
    endtask
    initial
    begin
        rst_n = 1'b0;
        ext_ev = 1'b0;
        req = '0;
        pin = '0;
        ev = '0;
        errors = 0;
        check_count = 0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        wb(1'b0, OFS_APP_IRQ_RST, 32'h0);
        chk("app_rst", rd, 32'hfa05_0000);
        wb(1'b0, OFS_SLEEP_CTRL, 32'h0);
        chk("slp_rst", rd, 32'h0);
        // Unkeyed write must be dropped
        wb(1'b1, OFS_APP_IRQ_RST, 32'h0000_0300);
        wb(1'b0, OFS_APP_IRQ_RST, 32'h0);
        chk("no_key", rd, 32'hfa05_0000);
        // Fixed and reserved bits hold under a keyed write
        wb(1'b1, OFS_APP_IRQ_RST, 32'h05fa_fef8);
        wb(1'b0, OFS_APP_IRQ_RST, 32'h0);
        chk("split_rw", rd, 32'hfa05_0600);
        chk("no_req", 32'(rst_req), 32'h0);
        $display("register test done");
        // Every split value, against a larger group except at split 7 where both groups are empty, then only sub bits differ against an equal group
        for (int n = 0; n < 8; n++)
        begin
            wb(1'b1, OFS_APP_IRQ_RST, {WRITE_KEY, 5'h0, n[2:0], 8'h0});
            msk = 8'hff << (n + 1);
            for (int k = 0; k < 2; k++)
            begin
                @(posedge clk);
                pin <= '{(k == 1) ? 8'hb6 : 8'h36, 8'hb7, 1'b1};
                wt(2);
                chk("group", 32'(pout.group), 32'(pin.pend_prio & msk));
                chk("sub", 32'(pout.sub), 32'(pin.pend_prio & ~msk));
                chk("preempt", 32'(pout.preempt), 32'((pin.pend_prio & msk) < (8'hb7 & msk)));
            end
        end
        $display("priority test done");
        wb(1'b1, OFS_SLEEP_CTRL, 32'hffff_ffff);
        wb(1'b0, OFS_SLEEP_CTRL, 32'h0);
        chk("slp_rw", rd, 32'h16);
        // Disabled interrupt wakes only with wake_any set
        wb(1'b1, OFS_SLEEP_CTRL, 32'h14);
        pulse(5'h10);
        chk("deep", 32'({sleeping, deep}), 32'h3);
        wake_base = wake_count;
        pulse(5'h04);
        chk("wake_dis", 32'({sleeping, wake_count != wake_base}), 32'h1);
        wb(1'b1, OFS_SLEEP_CTRL, 32'h0);
        pulse(5'h10);
        pulse(5'h04);
        chk("no_wake", 32'({sleeping, deep}), 32'h2);
        @(posedge clk);
        ext_ev <= 1'b1;
        wt(8);
        chk("ext_wake", 32'(sleeping), 32'h0);
        pulse(5'h10);
        pulse(5'h08);
        chk("sev_wake", 32'(sleeping), 32'h0);
        // Event in run is latched and eaten by the next wait
        pulse(5'h08);
        pulse(5'h10);
        chk("latched", 32'(sleeping), 32'h0);
        pulse(5'h10);
        chk("consumed", 32'(sleeping), 32'h1);
        pulse(5'h06);
        chk("irq_wake", 32'(sleeping), 32'h0);
        $display("wait test done");
        wb(1'b1, OFS_SLEEP_CTRL, 32'h2);
        pulse(5'h01);
        chk("exit_slp", 32'(sleeping), 32'h1);
        pulse(5'h06);
        chk("exit_wake", 32'(sleeping), 32'h0);
        wb(1'b1, OFS_SLEEP_CTRL, 32'h0);
        pulse(5'h01);
        chk("exit_run", 32'(sleeping), 32'h0);
        wb(1'b0, 4'h8, 32'h0);
        chk("unmapped", rd, 32'h0);
        wb(1'b1, OFS_APP_IRQ_RST, 32'h05fa_0704);
        chk("rst_req", 32'(rst_req), 32'h1);
        wb(1'b0, OFS_APP_IRQ_RST, 32'h0);
        chk("req_rd0", rd, 32'hfa05_0700);
        // outer system answers with a reset
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        chk("req_clr", 32'(rst_req), 32'h0);
        wb(1'b0, OFS_APP_IRQ_RST, 32'h0);
        chk("split_rst", rd, 32'hfa05_0000);
        $display("sleep and reset test done");
        test_done();
    end
endmodule
bind interrupt_reset_sleep_control sysctl_chk sysctl_chk_i (.CLK(CLK), .RST_N(RST_N),
    .WB_REQ(WB_REQ), .WB_RSP(WB_RSP), .PRIO_IN(PRIO_IN), .PRIO_OUT(PRIO_OUT),
    .SLEEPING(SLEEPING), .SLEEP_DEEP(SLEEP_DEEP), .WAKE(WAKE),
    .OUTER_RESET_REQUEST(OUTER_RESET_REQUEST));
`default_nettype wire
